// >>> rtl/rail_seq_pkg.sv
package rail_seq_pkg;

  // clock rate and printed times
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned MAIN_FILT_NS   = 5000;
  localparam int unsigned TERM_FILT_NS   = 50000;
  localparam int unsigned NOC_WAIT_NS    = 2500;
  localparam int unsigned NOC_PULSE_NS   = 300;

  // least times round up to whole cycles
  localparam int unsigned MAIN_FILT_CYC  = (MAIN_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TERM_FILT_CYC  = (TERM_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NOC_WAIT_CYC   = (NOC_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NOC_PULSE_CYC  = (NOC_PULSE_NS * CLK_MHZ + 999) / 1000;

  // soft-start: four phases of equal switching-cycle count
  localparam int unsigned SS_PHASE_CYC   = 110;
  localparam int unsigned SS_TOTAL_CYC   = 4 * SS_PHASE_CYC;

  localparam int unsigned FILT_W         = 14;
  localparam int unsigned SW_CNT_W       = 10;
  localparam int unsigned SS_CNT_W       = 9;

  // analog comparator results, high when the named condition is true
  typedef struct packed {
    logic por_ok;            // chip_supply above power-on level
    logic supply_above_on;   // chip_supply above upper lockout level
    logic supply_above_off;  // chip_supply above lower lockout level
    logic main_above_window; // main_rail above upper window / ov margin
    logic main_below_window; // main_rail below lower window limit
    logic main_above_pg;     // main_rail above power-good start fraction
    logic main_below_uv;     // main_rail below under-voltage margin
    logic main_above_half_v; // main_rail above reference start level
    logic term_above_ov;     // termination_rail above its ov margin
    logic term_below_uv;     // termination_rail below its uv margin
    logic valley_over_limit; // sensed valley current above limit
    logic phase_neg_oc;      // phase_node above negative oc threshold
    logic phase_low;         // phase_node below dead-time level
    logic low_gate_low;      // low_side_gate below dead-time level
    logic on_request;        // loop asks for a high-side on-time
    logic on_time_done;      // on-time one-shot expired
  } cmp_type;

  typedef struct packed {
    cmp_type cmp;
    logic    enable;         // enable_powersave_pin level
    logic    term_enable;    // termination_enable level
  } in_type;

  typedef struct packed {
    logic high_on;           // high_side_gate drive
    logic low_on;            // low_side_gate drive
    logic tristate;          // both gate drivers tri-stated
  } gates_type;

  typedef struct packed {
    logic       limit_src_en;  // threshold current source on
    logic [1:0] limit_step;    // 0..3 = 25/50/75/100 percent limit
    logic       double_min_off;
    logic       on_offset_en;  // positive on-time offset
  } ss_ctrl_type;

  typedef struct packed {
    logic ref_on;
    logic ref_hiz;
    logic term_on;
    logic term_hiz;
    logic main_hiz;
    logic discharge;         // active discharge of all three outputs
  } rails_type;

  typedef enum logic [4:0] {
    ST_LOCKOUT   = 5'h01,
    ST_DISABLED  = 5'h02,
    ST_SOFTSTART = 5'h04,
    ST_RUN       = 5'h08,
    ST_FAULT     = 5'h10
  } seq_state_type;

  typedef enum logic [6:0] {
    SW_IDLE      = 7'h01,
    SW_LOW       = 7'h02,
    SW_DEAD_LH   = 7'h04,
    SW_HIGH      = 7'h08,
    SW_DEAD_HL   = 7'h10,
    SW_NOC_WAIT  = 7'h20,
    SW_NOC_PULSE = 7'h40
  } sw_state_type;

  typedef struct packed {
    in_type                sync1;
    in_type                sync2;
    seq_state_type         seq;
    sw_state_type          sw;
    logic [SW_CNT_W-1:0]   sw_cnt;
    logic [SS_CNT_W-1:0]   ss_cnt;
    logic [FILT_W-1:0]     pg_cnt;
    logic [FILT_W-1:0]     ovm_cnt;
    logic [FILT_W-1:0]     uvm_cnt;
    logic [FILT_W-1:0]     ovt_cnt;
    logic [FILT_W-1:0]     uvt_cnt;
    logic                  pg;
    logic                  main_ov;
    logic                  main_uv;
    logic                  term_fault;
    logic                  ref_on;
  } state_type;

endpackage

// >>> rtl/rail_softstart_fault_sequencer.sv
`timescale 1ns/1ps

module rail_softstart_fault_sequencer #(
  parameter int unsigned TERM_FILT_CYC = rail_seq_pkg::TERM_FILT_CYC
) (
  input  wire logic                      core_clk,          // 250 MHz clock
  input  wire logic                      reset_n,           // async reset
  input  wire rail_seq_pkg::cmp_type     cmp,               // comparators
  input  wire logic                      enable_powersave_pin, // main enable
  input  wire logic                      termination_enable, // term enable
  output      rail_seq_pkg::gates_type   gates,             // gate drive
  output      rail_seq_pkg::ss_ctrl_type softstart,         // limit control
  output      rail_seq_pkg::rails_type   rails,             // rail control
  output      logic                      power_good_out_o,  // always low
  output      logic                      power_good_out_oe  // pulls low
);

  rail_seq_pkg::state_type st_ff;
  rail_seq_pkg::state_type nxt_st;
  rail_seq_pkg::in_type    s;
  logic                    supply_ok;
  logic                    switching;
  logic                    pg_raw;
  logic [1:0]              step;

  localparam logic [rail_seq_pkg::FILT_W-1:0] MAIN_LIM =
    rail_seq_pkg::FILT_W'(rail_seq_pkg::MAIN_FILT_CYC);
  localparam logic [rail_seq_pkg::FILT_W-1:0] TERM_LIM =
    rail_seq_pkg::FILT_W'(TERM_FILT_CYC);
  localparam logic [rail_seq_pkg::SW_CNT_W-1:0] WAIT_LAST =
    rail_seq_pkg::SW_CNT_W'(rail_seq_pkg::NOC_WAIT_CYC - 1);
  localparam logic [rail_seq_pkg::SW_CNT_W-1:0] PULSE_LAST =
    rail_seq_pkg::SW_CNT_W'(rail_seq_pkg::NOC_PULSE_CYC - 1);
  localparam logic [rail_seq_pkg::SS_CNT_W-1:0] SS_P1 =
    rail_seq_pkg::SS_CNT_W'(rail_seq_pkg::SS_PHASE_CYC);
  localparam logic [rail_seq_pkg::SS_CNT_W-1:0] SS_P2 =
    rail_seq_pkg::SS_CNT_W'(2 * rail_seq_pkg::SS_PHASE_CYC);
  localparam logic [rail_seq_pkg::SS_CNT_W-1:0] SS_P3 =
    rail_seq_pkg::SS_CNT_W'(3 * rail_seq_pkg::SS_PHASE_CYC);
  localparam logic [rail_seq_pkg::SS_CNT_W-1:0] SS_END =
    rail_seq_pkg::SS_CNT_W'(rail_seq_pkg::SS_TOTAL_CYC);

  // saturating persistence counter; a condition trips once it reaches lim
  function automatic logic [rail_seq_pkg::FILT_W-1:0] filt_next(
    input logic [rail_seq_pkg::FILT_W-1:0] c,
    input logic                            cond,
    input logic [rail_seq_pkg::FILT_W-1:0] lim
  );
    if (!cond) begin
      return '0;
    end else if (c >= lim) begin
      return lim;
    end else begin
      return c + rail_seq_pkg::FILT_W'(1);
    end
  endfunction

  // low-side turn-on: counts one switching cycle toward soft-start end
  function automatic logic [rail_seq_pkg::SS_CNT_W-1:0] ss_next(
    input logic [rail_seq_pkg::SS_CNT_W-1:0] c
  );
    if (c >= SS_END) begin
      return SS_END;
    end else begin
      return c + rail_seq_pkg::SS_CNT_W'(1);
    end
  endfunction

  always_comb begin
    nxt_st       = st_ff;
    s            = st_ff.sync2;
    nxt_st.sync1 = '{cmp: cmp, enable: enable_powersave_pin,
                     term_enable: termination_enable};
    nxt_st.sync2 = st_ff.sync1;

    // lockout hysteresis: rise past upper level, fall past lower one
    if (st_ff.seq == rail_seq_pkg::ST_LOCKOUT) begin
      supply_ok = s.cmp.por_ok && s.cmp.supply_above_on;
    end else begin
      supply_ok = s.cmp.por_ok && s.cmp.supply_above_off;
    end
    switching = (st_ff.seq == rail_seq_pkg::ST_SOFTSTART) ||
                (st_ff.seq == rail_seq_pkg::ST_RUN);

    if (st_ff.ss_cnt < SS_P1) begin
      step = 2'h0;
    end else if (st_ff.ss_cnt < SS_P2) begin
      step = 2'h1;
    end else if (st_ff.ss_cnt < SS_P3) begin
      step = 2'h2;
    end else begin
      step = 2'h3;
    end

    // main-rail fault filters: ov while switching, uv only at full limit
    nxt_st.ovm_cnt = filt_next(st_ff.ovm_cnt,
                               switching && s.cmp.main_above_window,
                               MAIN_LIM);
    nxt_st.uvm_cnt = filt_next(st_ff.uvm_cnt,
                               st_ff.seq == rail_seq_pkg::ST_RUN &&
                               s.cmp.main_below_uv, MAIN_LIM);

    // termination-rail fault filters, watched only while it is on
    nxt_st.ovt_cnt = filt_next(st_ff.ovt_cnt,
                               rails.term_on && s.cmp.term_above_ov,
                               TERM_LIM);
    nxt_st.uvt_cnt = filt_next(st_ff.uvt_cnt,
                               rails.term_on && s.cmp.term_below_uv,
                               TERM_LIM);
    // a trip in the same cycle as the clear wins; it drops next cycle
    if (!s.term_enable) begin
      nxt_st.term_fault = 1'b0;
    end
    if (st_ff.ovt_cnt == TERM_LIM || st_ff.uvt_cnt == TERM_LIM) begin
      nxt_st.term_fault = 1'b1;
    end

    // reference follows the main rail once it passes the start level
    if (switching && s.cmp.main_above_half_v) begin
      nxt_st.ref_on = 1'b1;
    end
    if (st_ff.seq == rail_seq_pkg::ST_FAULT &&
        !s.cmp.main_above_half_v) begin
      nxt_st.ref_on = 1'b0;
    end

    // switching sequencer
    if (switching) begin
      case (st_ff.sw)
        rail_seq_pkg::SW_IDLE: begin
          nxt_st.sw     = rail_seq_pkg::SW_LOW;
          nxt_st.ss_cnt = ss_next(st_ff.ss_cnt);
        end
        rail_seq_pkg::SW_LOW: begin
          if (s.cmp.phase_neg_oc) begin
            nxt_st.sw     = rail_seq_pkg::SW_NOC_WAIT;
            nxt_st.sw_cnt = '0;
          end else if (s.cmp.on_request && !s.cmp.valley_over_limit) begin
            nxt_st.sw = rail_seq_pkg::SW_DEAD_LH;
          end
        end
        rail_seq_pkg::SW_DEAD_LH: begin
          // valley check repeated: limit may rise while the gate discharges
          if (s.cmp.valley_over_limit) begin
            nxt_st.sw     = rail_seq_pkg::SW_LOW;
            nxt_st.ss_cnt = ss_next(st_ff.ss_cnt);
          end else if (s.cmp.low_gate_low) begin
            nxt_st.sw = rail_seq_pkg::SW_HIGH;
          end
        end
        rail_seq_pkg::SW_HIGH: begin
          if (s.cmp.on_time_done) begin
            nxt_st.sw = rail_seq_pkg::SW_DEAD_HL;
          end
        end
        rail_seq_pkg::SW_DEAD_HL: begin
          if (s.cmp.phase_low) begin
            nxt_st.sw     = rail_seq_pkg::SW_LOW;
            nxt_st.ss_cnt = ss_next(st_ff.ss_cnt);
          end
        end
        rail_seq_pkg::SW_NOC_WAIT: begin
          nxt_st.sw_cnt = st_ff.sw_cnt + rail_seq_pkg::SW_CNT_W'(1);
          if (st_ff.sw_cnt >= WAIT_LAST) begin
            nxt_st.sw     = rail_seq_pkg::SW_NOC_PULSE;
            nxt_st.sw_cnt = '0;
          end
        end
        rail_seq_pkg::SW_NOC_PULSE: begin
          nxt_st.sw_cnt = st_ff.sw_cnt + rail_seq_pkg::SW_CNT_W'(1);
          if (st_ff.sw_cnt >= PULSE_LAST) begin
            nxt_st.sw_cnt = '0;
            if (s.cmp.phase_neg_oc) begin
              nxt_st.sw = rail_seq_pkg::SW_NOC_WAIT;
            end else begin
              nxt_st.sw = rail_seq_pkg::SW_LOW;
            end
          end
        end
        default: begin
          nxt_st.sw = rail_seq_pkg::SW_IDLE;
        end
      endcase
    end else begin
      nxt_st.sw     = rail_seq_pkg::SW_IDLE;
      nxt_st.sw_cnt = '0;
    end

    // top-level sequence; the enable-low and supply-loss blocks below override it
    case (st_ff.seq)
      rail_seq_pkg::ST_LOCKOUT: begin
        nxt_st.seq = rail_seq_pkg::ST_DISABLED;
      end
      rail_seq_pkg::ST_DISABLED: begin
        if (s.enable) begin
          nxt_st.seq = rail_seq_pkg::ST_SOFTSTART;
        end
      end
      rail_seq_pkg::ST_SOFTSTART: begin
        if (st_ff.ss_cnt >= SS_END) begin
          nxt_st.seq = rail_seq_pkg::ST_RUN;
        end
      end
      default: begin
      end
    endcase
    if (switching && st_ff.ovm_cnt == MAIN_LIM) begin
      nxt_st.seq     = rail_seq_pkg::ST_FAULT;
      nxt_st.main_ov = 1'b1;
    end else if (switching && st_ff.uvm_cnt == MAIN_LIM) begin
      nxt_st.seq     = rail_seq_pkg::ST_FAULT;
      nxt_st.main_uv = 1'b1;
    end

    // power good: raw condition, then filtered in both directions
    pg_raw = (st_ff.seq == rail_seq_pkg::ST_RUN) &&
             s.cmp.main_above_pg &&
             !s.cmp.main_above_window && !s.cmp.main_below_window;
    nxt_st.pg_cnt = filt_next(st_ff.pg_cnt, pg_raw != st_ff.pg,
                              MAIN_LIM);
    if (st_ff.pg_cnt == MAIN_LIM) begin
      nxt_st.pg     = pg_raw;
      nxt_st.pg_cnt = '0;
    end

    // enable low: shut down and clear latches, whatever term enable says
    if (!s.enable) begin
      nxt_st.seq        = rail_seq_pkg::ST_DISABLED;
      nxt_st.main_ov    = 1'b0;
      nxt_st.main_uv    = 1'b0;
      nxt_st.term_fault = 1'b0;
      nxt_st.ss_cnt     = '0;
      nxt_st.ref_on     = 1'b0;
      nxt_st.sw         = rail_seq_pkg::SW_IDLE;
    end

    // supply loss has the last word: full inhibit and clear
    if (!supply_ok) begin
      nxt_st.seq        = rail_seq_pkg::ST_LOCKOUT;
      nxt_st.main_ov    = 1'b0;
      nxt_st.main_uv    = 1'b0;
      nxt_st.term_fault = 1'b0;
      nxt_st.ss_cnt     = '0;
      nxt_st.ref_on     = 1'b0;
      nxt_st.sw         = rail_seq_pkg::SW_IDLE;
      nxt_st.pg         = 1'b0;
      nxt_st.pg_cnt     = '0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff     <= '0;
      st_ff.seq <= rail_seq_pkg::ST_LOCKOUT;
      st_ff.sw  <= rail_seq_pkg::SW_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs decode registered state only
  always_comb begin
    gates = '0;
    if (st_ff.seq == rail_seq_pkg::ST_LOCKOUT) begin
      gates.tristate = 1'b1;
    end else if (st_ff.seq == rail_seq_pkg::ST_FAULT) begin
      gates.low_on   = st_ff.main_ov;
      gates.tristate = !st_ff.main_ov;
    end else if (st_ff.seq == rail_seq_pkg::ST_DISABLED) begin
      gates.tristate = 1'b0;
    end else begin
      gates.high_on = (st_ff.sw == rail_seq_pkg::SW_HIGH);
      gates.low_on  = (st_ff.sw == rail_seq_pkg::SW_LOW) ||
                      (st_ff.sw == rail_seq_pkg::SW_NOC_PULSE);
    end
  end

  always_comb begin
    softstart              = '0;
    softstart.limit_src_en = gates.low_on && !gates.tristate &&
                             st_ff.seq != rail_seq_pkg::ST_FAULT;
    if (st_ff.seq == rail_seq_pkg::ST_SOFTSTART) begin
      softstart.limit_step     = step;
      softstart.double_min_off = (step == 2'h0);
      softstart.on_offset_en   = (step == 2'h0);
    end else begin
      softstart.limit_step = 2'h3;
    end
  end

  always_comb begin
    rails           = '0;
    rails.discharge = (st_ff.seq == rail_seq_pkg::ST_DISABLED);
    rails.ref_on    = st_ff.ref_on;
    rails.ref_hiz   = !st_ff.ref_on && !rails.discharge;
    rails.term_on   = st_ff.ref_on && st_ff.sync2.term_enable &&
                      !st_ff.term_fault;
    rails.term_hiz  = !rails.term_on && !rails.discharge;
    rails.main_hiz  = gates.tristate;
  end

  assign power_good_out_o  = 1'b0;
  assign power_good_out_oe = !st_ff.pg;

endmodule // rail_softstart_fault_sequencer

// >>> testbench/rail_partner_model.sv
`timescale 1ns/1ps
module rail_partner_model (
  input  wire logic                    core_clk,     // clock
  input  wire rail_seq_pkg::gates_type gates,        // gate drive in
  input  wire logic                    slow,         // stretch fet delays
  output      logic                    phase_low,    // phase node low
  output      logic                    low_gate_low, // low gate discharged
  output      logic                    on_request,   // loop wants on-time
  output      logic                    on_time_done  // on-time expired
);
  logic [3:0] lo_q;
  logic [3:0] hi_q;
  logic [3:0] on_cnt;
  // gate and node levels trail the drive, longer when slow is set
  always_ff @(posedge core_clk) begin
    lo_q   <= {lo_q[2:0], gates.low_on};
    hi_q   <= {hi_q[2:0], gates.high_on};
    on_cnt <= gates.high_on ? on_cnt + 4'h1 : 4'h0;
  end
  assign low_gate_low = !(slow ? |lo_q : lo_q[0]);
  assign phase_low    = !(slow ? |hi_q : hi_q[0]);
  assign on_request   = lo_q[2];
  assign on_time_done = on_cnt >= 4'h4;
endmodule // rail_partner_model

// >>> testbench/rail_seq_monitor.sv
`timescale 1ns/1ps
module rail_seq_monitor #(
  parameter int unsigned TERM_FILT_CYC = 20
) (
  input wire logic                      core_clk,             // clock
  input wire logic                      reset_n,              // async reset
  input wire rail_seq_pkg::cmp_type     cmp,                  // comparators
  input wire logic                      enable_powersave_pin, // main enable
  input wire logic                      termination_enable,   // term enable
  input wire rail_seq_pkg::gates_type   gates,                // gate drive
  input wire rail_seq_pkg::ss_ctrl_type softstart,            // limit ctrl
  input wire rail_seq_pkg::rails_type   rails,                // rail ctrl
  input wire logic                      power_good_out_o,     // pin data
  input wire logic                      power_good_out_oe     // pulls low
);
  logic [11:0] good_cnt_ff;
  logic [11:0] ov_cnt_ff;
  logic        low_seen_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // run lengths on the raw inputs; the design sees them three edges later
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      good_cnt_ff <= 12'h000;
      ov_cnt_ff   <= 12'h000;
      low_seen_ff <= 1'b0;
    end else begin
      good_cnt_ff <= (cmp.main_above_pg && !cmp.main_above_window &&
        !cmp.main_below_window) ? good_cnt_ff + 12'h001 : 12'h000;
      ov_cnt_ff   <= (cmp.main_above_window && enable_powersave_pin) ?
        ov_cnt_ff + 12'h001 : 12'h000;
      low_seen_ff <= gates.low_on ||
        (low_seen_ff && !gates.tristate && !rails.discharge);
    end
  end
  sequence hi_start;
    $rose(gates.high_on);
  endsequence
  sequence low_leave;
    $fell(gates.low_on) && !gates.tristate;
  endsequence
  no_shoot_a: assert property (!(gates.high_on && gates.low_on))
    else $error("both gate drives on");
  high_wait_a: assert property (hi_start |-> $past(cmp.low_gate_low, 3))
    else $error("high side on before low gate fell");
  valley_block_a: assert property (low_leave ##0
    $past(enable_powersave_pin, 3) && !$past(cmp.phase_neg_oc, 3)
    |-> !$past(cmp.valley_over_limit, 3))
    else $error("low side left while valley over limit");
  first_low_a: assert property (hi_start |-> low_seen_ff)
    else $error("high side before any low pulse");
  pg_release_a: assert property ($fell(power_good_out_oe)
    |-> good_cnt_ff >= 12'h4E2)
    else $error("power good released without filter");
  ov_latch_a: assert property (ov_cnt_ff >= 12'h4EC
    |-> gates.low_on && !gates.high_on)
    else $error("over-voltage did not latch low side");
  supply_trip_a: assert property (!cmp.supply_above_off [*4]
    |-> gates.tristate && !gates.low_on && !gates.high_on)
    else $error("drivers not tri-stated on supply loss");
  term_off_a: assert property (!termination_enable [*4] |-> !rails.term_on)
    else $error("termination rail on while disabled");
  pin_low_a: assert property (!power_good_out_o)
    else $error("power good pin data not low");
  src_high_a: assert property (gates.high_on |-> !softstart.limit_src_en)
    else $error("current source on with high side");
  shut_down_a: assert property (!enable_powersave_pin [*4]
    |-> !gates.high_on && !gates.low_on && !rails.ref_on && !rails.term_on)
    else $error("outputs active with enable low");
endmodule // rail_seq_monitor
bind rail_softstart_fault_sequencer rail_seq_monitor #(
  .TERM_FILT_CYC(TERM_FILT_CYC)
) u_mon (
  .core_clk(core_clk), .reset_n(reset_n), .cmp(cmp),
  .enable_powersave_pin(enable_powersave_pin),
  .termination_enable(termination_enable), .gates(gates),
  .softstart(softstart), .rails(rails),
  .power_good_out_o(power_good_out_o),
  .power_good_out_oe(power_good_out_oe));

// >>> testbench/rail_softstart_fault_sequencer_tb.sv
`timescale 1ns/1ps
module rail_softstart_fault_sequencer_tb;
  localparam int TERM_LIM  = 20;
  localparam int WATCH_CYC = 60000;
  typedef struct packed {logic [1:0] kind; logic [5:0] val;} note_type;
  logic                      core_clk, reset_n, slow, power_good_out_oe;
  logic                      enable_powersave_pin, termination_enable;
  logic                      p_phase, p_lgate, p_req, p_done;
  rail_seq_pkg::cmp_type     drv, cmp;
  rail_seq_pkg::gates_type   gates;
  rail_seq_pkg::ss_ctrl_type softstart;
  rail_seq_pkg::rails_type   rails;
  note_type                  notes[$];
  note_type                  n;
  integer                    num_errors, samples_checked, seed, i, k;
  always_comb begin
    cmp              = drv;
    cmp.phase_low    = p_phase;
    cmp.low_gate_low = p_lgate;
    cmp.on_request   = p_req;
    cmp.on_time_done = p_done;
  end
  rail_softstart_fault_sequencer #(.TERM_FILT_CYC(TERM_LIM)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .cmp(cmp),
    .enable_powersave_pin(enable_powersave_pin),
    .termination_enable(termination_enable), .gates(gates),
    .softstart(softstart), .rails(rails), .power_good_out_o(),
    .power_good_out_oe(power_good_out_oe));
  rail_partner_model u_fets (.core_clk(core_clk), .gates(gates),
    .slow(slow), .phase_low(p_phase), .low_gate_low(p_lgate),
    .on_request(p_req), .on_time_done(p_done));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic tick(input int cyc);
    repeat (cyc) @(negedge core_clk);
  endtask
  task automatic note(input logic [1:0] kind, input logic [5:0] val);
    notes.push_back('{kind, val});
  endtask
  task automatic tally(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask
  task automatic cmp_gates(input logic [2:0] v);
    tally(gates === v, "gate drive");
  endtask
  task automatic cmp_rails(input logic [5:0] v);
    tally(rails === v, "rail control");
  endtask
  task automatic cmp_ss(input logic [4:0] v);
    tally(softstart === v, "soft-start");
  endtask
  task automatic cmp_pg(input logic v);
    tally(power_good_out_oe === v, "power good");
  endtask
  // outputs only move on rising edges, so 1 ns past the falling edge is safe
  initial begin
    forever begin
      @(negedge core_clk);
      #1;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.kind)
          2'h0: cmp_gates(n.val[2:0]);
          2'h1: cmp_rails(n.val);
          2'h2: cmp_ss(n.val[4:0]);
          default: cmp_pg(n.val[0]);
        endcase
      end
    end
  end
  // random valley trips and slow fets stress the switching handshake
  initial begin
    forever begin
      @(negedge core_clk);
      drv.valley_over_limit = ($random(seed) & 7) == 0;
      slow = ($random(seed) & 3) == 0;
    end
  end
  task automatic power_up();
    int   sw;
    int   guard;
    logic lo_d;
    sw = 0;
    guard = 0;
    lo_d = 1'b0;
    enable_powersave_pin = 1'b1;
    while (sw < 440 && guard < 30000) begin
      tick(1);
      guard++;
      if (gates.low_on && !lo_d) begin
        sw++;
        if (sw % 110 == 50) note(2'h2, {2'h1, 2'(sw / 110), sw < 110, sw < 110});
        if (sw == 380) note(2'h3, 6'h01);
      end
      lo_d = gates.low_on;
    end
    if (guard >= 30000) tally(1'b0, "soft-start length");
    tick(1300);
    note(2'h1, 6'h28);
    note(2'h3, 6'h00);
    $display("power-up test done");
  endtask
  task automatic run_checks();
    drv.main_below_window = 1'b1;
    tick(500);
    note(2'h3, 6'h00);
    tick(800);
    note(2'h3, 6'h01);
    drv.main_below_window = 1'b0;
    tick(1300);
    note(2'h3, 6'h00);
    for (k = 0; k < 2; k++) begin
      if (k == 0) drv.term_above_ov = 1'b1;
      else drv.term_below_uv = 1'b1;
      tick(TERM_LIM + 20);
      note(2'h1, 6'h24);
      drv.term_above_ov = 1'b0;
      drv.term_below_uv = 1'b0;
      termination_enable = 1'b0;
      tick(10);
      note(2'h1, 6'h24);
      termination_enable = 1'b1;
      tick(10);
      note(2'h1, 6'h28);
    end
    drv.phase_neg_oc = 1'b1;
    tick(60);
    note(2'h0, 6'h00);
    tick(540);
    note(2'h0, 6'h00);
    tick(70);
    note(2'h0, 6'h02);
    drv.phase_neg_oc = 1'b0;
    tick(100);
    $display("window, termination and negative current tests done");
  endtask
  task automatic main_fault(input int f);
    if (f == 0) drv.main_above_window = 1'b1;
    else drv.main_below_uv = 1'b1;
    tick(1300);
    note(2'h0, f ? 6'h01 : 6'h02);
    drv.main_above_half_v = 1'b0;
    tick(10);
    note(2'h1, f ? 6'h16 : 6'h14);
    drv.main_above_window = 1'b0;
    drv.main_below_uv = 1'b0;
    drv.main_above_half_v = 1'b1;
    tick(10);
    note(2'h0, f ? 6'h01 : 6'h02);
    enable_powersave_pin = 1'b0;
    tick(10);
    $display("main fault test %0d done", f);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(4 * WATCH_CYC);
    num_errors++;
    summarize();
  end
  initial begin
    seed = 32'hE008;
    num_errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    drv = '0;
    slow = 1'b0;
    enable_powersave_pin = 1'b0;
    termination_enable = 1'b1;
    tick(6);
    note(2'h0, 6'h01);
    note(2'h1, 6'h16);
    note(2'h2, 6'h0C);
    note(2'h3, 6'h01);
    reset_n = 1'b1;
    drv.por_ok = 1'b1;
    tick(10);
    note(2'h0, 6'h01);
    drv.supply_above_on = 1'b1;
    drv.supply_above_off = 1'b1;
    drv.main_above_pg = 1'b1;
    drv.main_above_half_v = 1'b1;
    for (i = 0; i < 2; i++) begin
      power_up();
      if (i == 0) run_checks();
      main_fault(i);
    end
    drv.supply_above_on = 1'b0;
    drv.supply_above_off = 1'b0;
    tick(8);
    note(2'h0, 6'h01);
    tick(2);
    summarize();
  end
endmodule // rail_softstart_fault_sequencer_tb
